// ==== hdl/tws_pkg.sv ====
// Package of constants, states and carrier types for the three-wire serial configuration port.
package tws_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [6:0] ADDR_STATUS     = 7'h6E;
  localparam logic [6:0] ADDR_ALIGN_CTRL = 7'h18;
  localparam logic [6:0] ADDR_SPI_CTRL   = 7'h6C;
  localparam logic [6:0] ADDR_CAL_CTRL   = 7'h6D;
  localparam logic [6:0] ADDR_INIT_CTRL  = 7'h6F;
  localparam logic [6:0] ADDR_SYSREF_CTL = 7'h70;
  localparam logic [6:0] ADDR_CLK_OE     = 7'h74;
  localparam logic [6:0] ADDR_SYS_OE     = 7'h76;
  localparam logic [6:0] ADDR_FORBID_LO  = 7'h78;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BIT_READY       = 1;
  localparam int BIT_ALIGN_ACT   = 2;
  localparam int BIT_ALIGN_START = 0;
  localparam int BIT_READ_EDGE   = 0;
  localparam int BIT_BIAS_CAL    = 0;
  localparam int BIT_DELAY_CAL   = 1;
  localparam int BIT_DIV_INIT    = 0;
  localparam int BIT_COUPLING    = 0;
  localparam int BIT_SYS_PD      = 1;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_CLK_OE = 8'hFF;
  localparam logic [7:0] RST_SYS_OE = 8'h00;
  localparam logic [7:0] RST_ZERO   = 8'h00;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ         = 250;
  localparam int CLK_OFF_MS      = 2;
  localparam int CLK_OFF_CYCLES  = CLK_OFF_MS * 1000 * CLK_MHZ;
  localparam int OP_BUSY_CYCLES  = 16;
  localparam int FIFO_DEPTH_DEF  = 8;

  // Serial state.
  typedef enum logic [1:0] {
    TWS_IDLE  = 2'b00,
    TWS_CMD   = 2'b01,
    TWS_WRITE = 2'b10,
    TWS_READ  = 2'b11
  } tws_state_t;

  // One received write byte with its target address.
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } tws_wr_t;

endpackage

// ==== hdl/tws_fifo.sv ====
// Parameterised valid/ready FIFO carrying received write bytes.
`timescale 1ns/1ps
`default_nettype none
module tws_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Pointer wrap relies on a power-of-two depth of at least 2, so refuse any other.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_ff;
  logic [AW:0]      rd_ptr_ff;
  wire              push = ce && in_valid && in_ready;
  wire              pop  = ce && out_valid && out_ready;

  // Full when pointers differ only in the wrap bit.
  assign in_ready  = (wr_ptr_ff ^ rd_ptr_ff) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr_ff != rd_ptr_ff;
  assign out_data  = mem[rd_ptr_ff[AW-1:0]];

  // Storage has no reset; only valid entries are ever read.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  // Pointers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)  rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/tws_port.sv ====
// Three-wire serial slave port with start-up, alignment, calibration and init sequencing.
`timescale 1ns/1ps
`default_nettype none
module tws_port
  import tws_pkg::*;
#(
  parameter int CLK_OFF_CNT = CLK_OFF_CYCLES,
  parameter int FIFO_DEPTH  = FIFO_DEPTH_DEF
) (
  // Clock, reset, enable
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Serial pins
  input  wire logic       sclk_pin,
  input  wire logic       chip_select_n,
  input  wire logic       sdio_in,
  output logic            sdio_out,
  output logic            sdio_oe_n,
  // Analog-side handshakes
  input  wire logic       ref_in,
  input  wire logic       clk_valid,
  input  wire logic       align_done,
  input  wire logic       cal_done,
  input  wire logic       init_done,
  // Controls to the analog side
  output logic            clk_input_enable,
  output logic            bias_cal_pulse,
  output logic            delay_cal_pulse,
  output logic            divider_init_pulse,
  output logic            align_run,
  output logic [7:0]      clock_output_en,
  output logic [7:0]      sysref_output_en,
  output logic            sysref_crosspoint
);
  // A zero start-up count would open the clock input at once, so refuse it.
  if (CLK_OFF_CNT < 1) begin : g_bad_off_cnt
    $error("CLK_OFF_CNT must be at least 1");
  end

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  // Two flops per pin; the first stage feeds only the second.
  logic [3:0] sy1_ff;
  logic [3:0] sy2_ff;
  logic [0:0] sclk_hist_ff;
  logic       ref_d_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sy1_ff <= 4'h2;  // Idle levels: select high, clock low, so no false edge.
      sy2_ff <= 4'h2;
    end else if (ce) begin
      sy1_ff <= {ref_in, sdio_in, chip_select_n, sclk_pin};
      sy2_ff <= sy1_ff;
    end
  end
  wire sclk_s = sy2_ff[0];
  wire cs_n_s = sy2_ff[1];
  wire sdi_s  = sy2_ff[2];
  wire ref_s  = sy2_ff[3];

  // Edge history on synchronised signals only.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_hist_ff <= 1'b0;
      ref_d_ff     <= 1'b0;
    end else if (ce) begin
      sclk_hist_ff <= sclk_s;
      ref_d_ff     <= ref_s;
    end
  end
  wire sclk_rise = sclk_s && !sclk_hist_ff[0];
  wire sclk_fall = !sclk_s && sclk_hist_ff[0];
  wire ref_rise  = ref_s && !ref_d_ff;

  // ************************************************************
  // Registers
  // ************************************************************
  logic       ready_ff;
  logic       align_start_ff;
  logic       align_act_ff;
  logic       align_seen_ff;
  logic       read_edge_ff;
  logic       bias_cal_ff;
  logic       delay_cal_ff;
  logic       div_init_ff;
  logic       coupling_ff;
  logic       sys_pd_ff;
  logic [7:0] clk_oe_ff;
  logic [7:0] sys_oe_ff;

  // Register read decode, used for the shift register load.
  function automatic logic [7:0] rd_mux(input logic [6:0] a);
    case (a)
      ADDR_STATUS:     rd_mux = 8'({align_act_ff, ready_ff, 1'b0} << (BIT_READY - 1));
      ADDR_ALIGN_CTRL: rd_mux = {7'h00, align_start_ff};
      ADDR_SPI_CTRL:   rd_mux = {7'h00, read_edge_ff};
      ADDR_CAL_CTRL:   rd_mux = {6'h00, delay_cal_ff, bias_cal_ff};
      ADDR_INIT_CTRL:  rd_mux = {7'h00, div_init_ff};
      ADDR_SYSREF_CTL: rd_mux = {6'h00, sys_pd_ff, coupling_ff};
      ADDR_CLK_OE:     rd_mux = clk_oe_ff;
      ADDR_SYS_OE:     rd_mux = sys_oe_ff;
      default:         rd_mux = 8'h00;
    endcase
  endfunction

  // ************************************************************
  // Serial engine
  // ************************************************************
  tws_state_t state_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [6:0] addr_ff;
  logic       drive_ff;
  logic       sdo_ff;
  logic       wr_valid_ff;
  tws_wr_t    wr_ff;
  logic       fifo_in_ready;

  wire        byte_end   = sclk_rise && (bit_cnt_ff == 3'h7);
  wire [7:0]  shift_in   = {sdi_s, shift_ff[7:1]};
  wire        tx_edge    = read_edge_ff ? sclk_rise : sclk_fall;
  wire [6:0]  addr_next  = addr_ff + 7'h01;

  // Serial state machine; select high returns it to idle and clears the bit count.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= TWS_IDLE;
      bit_cnt_ff <= 3'h0;
      shift_ff   <= 8'h00;
      addr_ff    <= 7'h00;
    end else if (ce) begin
      if (cs_n_s) begin
        state_ff   <= TWS_IDLE;
        bit_cnt_ff <= 3'h0;
      end else begin
        case (state_ff)
          TWS_IDLE: begin
            state_ff <= TWS_CMD;
          end
          TWS_CMD: begin
            if (sclk_rise) begin
              shift_ff   <= shift_in;
              bit_cnt_ff <= bit_cnt_ff + 3'h1;
            end
            if (byte_end) begin
              addr_ff  <= shift_in[7:1];
              state_ff <= shift_in[0] ? TWS_READ : TWS_WRITE;
              if (shift_in[0]) shift_ff <= rd_mux(shift_in[7:1]);
            end
          end
          TWS_WRITE: begin
            if (sclk_rise) begin
              shift_ff   <= shift_in;
              bit_cnt_ff <= bit_cnt_ff + 3'h1;
            end
            if (byte_end) addr_ff <= addr_next;
          end
          TWS_READ: begin
            if (sclk_rise) bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (tx_edge) shift_ff <= {1'b0, shift_ff[7:1]};
            if (byte_end) begin
              addr_ff  <= addr_next;
              shift_ff <= rd_mux(addr_next);
            end
          end
          default: state_ff <= TWS_IDLE;
        endcase
      end
    end
  end

  // Line driver: presents bit 0 on the chosen edge once in read phase.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_ff <= 1'b0;
      sdo_ff   <= 1'b0;
    end else if (ce) begin
      if (cs_n_s || state_ff != TWS_READ) begin
        drive_ff <= 1'b0;
      end else if (tx_edge) begin
        drive_ff <= 1'b1;
        sdo_ff   <= shift_ff[0];
      end
    end
  end
  assign sdio_out  = sdo_ff;
  assign sdio_oe_n = !drive_ff;

  // Completed write byte; partial bytes never reach here.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_valid_ff <= 1'b0;
      wr_ff       <= '0;
    end else if (ce) begin
      if (wr_valid_ff && fifo_in_ready) wr_valid_ff <= 1'b0;
      if (state_ff == TWS_WRITE && byte_end && !cs_n_s) begin
        wr_valid_ff <= 1'b1;
        wr_ff       <= '{addr: addr_ff, data: shift_in};
      end
    end
  end

  // ************************************************************
  // Write FIFO
  // ************************************************************
  logic    fifo_out_valid;
  tws_wr_t fifo_out;
  wire     commit_ready = !div_init_ff;  // Stall commits while init runs.

  tws_fifo #(.WIDTH($bits(tws_wr_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_valid  (wr_valid_ff),
    .in_ready  (fifo_in_ready),
    .in_data   (wr_ff),
    .out_valid (fifo_out_valid),
    .out_ready (commit_ready),
    .out_data  (fifo_out)
  );

  wire commit = fifo_out_valid && commit_ready;
  function automatic logic hit(input logic [6:0] a);
    hit = commit && (fifo_out.addr == a);
  endfunction
  wire [7:0] wd = fifo_out.data;

  // ************************************************************
  // Start-up timer and sequencing
  // ************************************************************
  logic [31:0] boot_cnt_ff;
  logic [4:0]  op_cnt_ff;
  wire         boot_done = boot_cnt_ff == 32'(CLK_OFF_CNT);

  // Clock input held off for the start-up interval.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_cnt_ff <= 32'h0;
      ready_ff    <= 1'b0;
    end else if (ce) begin
      if (!boot_done) boot_cnt_ff <= boot_cnt_ff + 32'h1;
      ready_ff <= boot_done;
    end
  end

  // Register write and self-clearing trigger bits; hardware clear never drops a new set.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      align_start_ff <= 1'b0;
      align_act_ff   <= 1'b0;
      align_seen_ff  <= 1'b0;
      read_edge_ff   <= 1'b0;
      bias_cal_ff    <= 1'b0;
      delay_cal_ff   <= 1'b0;
      div_init_ff    <= 1'b0;
      coupling_ff    <= 1'b0;
      sys_pd_ff      <= 1'b0;
      clk_oe_ff      <= RST_CLK_OE;
      sys_oe_ff      <= RST_SYS_OE;
      op_cnt_ff      <= 5'h0;
    end else if (ce) begin
      // Alignment: start bit hands over to the active flag, then clears.
      if (align_start_ff) begin
        align_start_ff <= 1'b0;
        align_act_ff   <= 1'b1;
        align_seen_ff  <= 1'b0;
      end else if (align_act_ff) begin
        if (ref_rise && clk_valid) align_seen_ff <= 1'b1;
        if (align_seen_ff && align_done) align_act_ff <= 1'b0;
      end
      // Calibration bits clear when the analog side reports done.
      if (cal_done) begin
        bias_cal_ff  <= 1'b0;
        delay_cal_ff <= 1'b0;
      end
      // Init runs at least a fixed time and until the analog side is done.
      if (div_init_ff) begin
        if (op_cnt_ff != 5'(OP_BUSY_CYCLES)) op_cnt_ff <= op_cnt_ff + 5'h1;
        else if (init_done) div_init_ff <= 1'b0;
      end
      if (hit(ADDR_ALIGN_CTRL) && wd[BIT_ALIGN_START]) align_start_ff <= 1'b1;
      if (hit(ADDR_SPI_CTRL))   read_edge_ff <= wd[BIT_READ_EDGE];
      if (hit(ADDR_CAL_CTRL)) begin
        if (wd[BIT_BIAS_CAL])  bias_cal_ff  <= 1'b1;
        if (wd[BIT_DELAY_CAL]) delay_cal_ff <= 1'b1;
      end
      if (hit(ADDR_INIT_CTRL) && wd[BIT_DIV_INIT]) begin
        div_init_ff <= 1'b1;
        op_cnt_ff   <= 5'h0;
      end
      if (hit(ADDR_SYSREF_CTL)) begin
        coupling_ff <= wd[BIT_COUPLING];
        sys_pd_ff   <= wd[BIT_SYS_PD];
      end
      if (hit(ADDR_CLK_OE)) clk_oe_ff <= wd;
      if (hit(ADDR_SYS_OE)) sys_oe_ff <= wd;
    end
  end

  // ************************************************************
  // Outputs, all registered
  // ************************************************************
  logic       cal_arm_ff;
  logic       xp_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_input_enable   <= 1'b0;
      bias_cal_pulse     <= 1'b0;
      delay_cal_pulse    <= 1'b0;
      divider_init_pulse <= 1'b0;
      align_run          <= 1'b0;
      clock_output_en    <= 8'h00;
      sysref_output_en   <= 8'h00;
      sysref_crosspoint  <= 1'b0;
      cal_arm_ff         <= 1'b0;
      xp_ff              <= 1'b0;
    end else if (ce) begin
      clk_input_enable   <= boot_done;
      cal_arm_ff         <= bias_cal_ff | delay_cal_ff;
      bias_cal_pulse     <= bias_cal_ff && !cal_arm_ff;
      delay_cal_pulse    <= delay_cal_ff && !cal_arm_ff;
      divider_init_pulse <= div_init_ff && op_cnt_ff == 5'h0;
      align_run          <= align_seen_ff && align_act_ff;
      clock_output_en    <= div_init_ff ? 8'h00 : clk_oe_ff;
      sysref_output_en   <= div_init_ff ? 8'h00 : sys_oe_ff;
      // Powerdown falling edge under AC coupling parks pairs at crosspoint.
      if (sys_pd_ff) xp_ff <= 1'b1;
      if (xp_ff && !sys_pd_ff && coupling_ff) sysref_crosspoint <= 1'b1;
      if (!sys_pd_ff) xp_ff <= 1'b0;
      if (!coupling_ff || ref_rise) sysref_crosspoint <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== tb/tws_port_properties.sv ====
// Checker of the serial port's pin-level behaviour, bound into the port.
`timescale 1ns/1ps
`default_nettype none
module tws_port_properties
  import tws_pkg::*;
#(
  parameter int CLK_OFF_CNT = CLK_OFF_CYCLES
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       ce,
  // Serial pins
  input wire logic       sclk_pin,
  input wire logic       chip_select_n,
  input wire logic       sdio_oe_n,
  // Controls
  input wire logic       clk_input_enable,
  input wire logic       bias_cal_pulse,
  input wire logic       delay_cal_pulse,
  input wire logic       divider_init_pulse,
  input wire logic [7:0] clock_output_en,
  input wire logic [7:0] sysref_output_en
);
  // ************************************************************
  // Helper counters
  // ************************************************************
  int   up_cnt;
  int   rise_cnt;
  logic sclk_q;

  // Cycles since reset and raw serial rises in the frame; the raw pin leads the
  // design's synchroniser, which the windows below allow for.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_cnt   <= 0;
      rise_cnt <= 0;
      sclk_q   <= 1'b0;
    end else begin
      sclk_q <= sclk_pin;
      if (ce && up_cnt < CLK_OFF_CNT + 16) begin
        up_cnt <= up_cnt + 1;
      end
      if (chip_select_n) begin
        rise_cnt <= 0;
      end else if (sclk_pin && !sclk_q) begin
        rise_cnt <= rise_cnt + 1;
      end
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  reset_values_a: assert property (
    $rose(rst_n) |=> clock_output_en == RST_CLK_OE && sysref_output_en == RST_SYS_OE)
    else $error("enables not at reset values");
  clock_gate_a: assert property (
    clk_input_enable |-> up_cnt >= CLK_OFF_CNT - 1)
    else $error("clock input opened too early");
  clock_open_a: assert property (
    up_cnt >= CLK_OFF_CNT + 4 |-> clk_input_enable)
    else $error("clock input still closed");
  released_idle_a: assert property (
    chip_select_n [*5] |-> sdio_oe_n)
    else $error("data line driven while deselected");
  drive_select_a: assert property (
    $fell(sdio_oe_n) |-> !chip_select_n)
    else $error("drive began outside a frame");
  drive_start_a: assert property (
    $fell(sdio_oe_n) |-> rise_cnt inside {[8:9]})
    else $error("drive began at wrong bit count");
  init_quiet_a: assert property (
    divider_init_pulse |-> ##2 (clock_output_en == 8'h00 && sysref_output_en == 8'h00) [*8])
    else $error("outputs not low during init");
  pulse_single_a: assert property (
    (bias_cal_pulse || delay_cal_pulse || divider_init_pulse)
    |=> !(bias_cal_pulse || delay_cal_pulse || divider_init_pulse))
    else $error("start pulse longer than one cycle");
  commit_edge_a: assert property (
    !chip_select_n && $changed(clock_output_en) |-> rise_cnt >= 16 && rise_cnt % 8 == 0)
    else $error("register changed inside a byte");
endmodule

bind tws_port tws_port_properties #(.CLK_OFF_CNT(CLK_OFF_CNT)) i_props (
  .clk                (clk),
  .rst_n              (rst_n),
  .ce                 (ce),
  .sclk_pin           (sclk_pin),
  .chip_select_n      (chip_select_n),
  .sdio_oe_n          (sdio_oe_n),
  .clk_input_enable   (clk_input_enable),
  .bias_cal_pulse     (bias_cal_pulse),
  .delay_cal_pulse    (delay_cal_pulse),
  .divider_init_pulse (divider_init_pulse),
  .clock_output_en    (clock_output_en),
  .sysref_output_en   (sysref_output_en)
);
`default_nettype wire

// ==== tb/tws_master_model.sv ====
// Behavioural serial master that frames bytes on the three-wire port.
`timescale 1ns/1ps
`default_nettype none
module tws_master_model (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic     sclk_pin,
  output logic     chip_select_n,
  output logic     sdio_line,
  input wire logic sdio_out,
  input wire logic sdio_oe_n
);
  logic m_bit;
  logic m_drv;

  // Resolved line: once we let go we show the inverse of our last bit, so a
  // device that fails to drive never echoes that bit, but still matches an expected byte of all inverse bits.
  assign sdio_line = sdio_oe_n ? m_bit : sdio_out;

  initial begin
    sclk_pin      = 1'b0;
    chip_select_n = 1'b1;
    m_bit         = 1'b0;
    m_drv         = 1'b0;
  end

  // One serial clock: low half, then high half; sample opposite the change.
  task automatic bit_cycle(input logic d, input logic drv, input logic e1, output logic q);
    @(posedge clk);
    sclk_pin <= 1'b0;
    if (drv) begin
      m_bit <= d;
    end else if (m_drv) begin
      m_bit <= ~m_bit;
    end
    m_drv <= drv;
    repeat (5) @(posedge clk);
    q = sdio_line;
    @(posedge clk);
    sclk_pin <= 1'b1;
    repeat (5) @(posedge clk);
    if (e1) begin
      q = sdio_line;
    end
  endtask

  task automatic send(input logic [7:0] b, input int n);
    logic q;
    for (int i = 0; i < n; i++) begin
      bit_cycle(b[i], 1'b1, 1'b0, q);
    end
  endtask

  task automatic recv(input logic e1, output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      bit_cycle(1'b0, 1'b0, e1, b[i]);
    end
  endtask

  task automatic open_frame();
    @(posedge clk);
    chip_select_n <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic close_frame();
    @(posedge clk);
    sclk_pin <= 1'b0;
    repeat (3) @(posedge clk);
    chip_select_n <= 1'b1;
    m_bit         <= ~m_bit;
    m_drv         <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== tb/three_wire_spi_config_port_tb_top.sv ====
// Self-checking testbench of the three-wire configuration port.
`timescale 1ns/1ps
`default_nettype none
module three_wire_spi_config_port_tb_top
  import tws_pkg::*;
;
  logic       clk;
  logic       rst_n;
  logic       ce;
  logic       sclk_pin;
  logic       chip_select_n;
  logic       sdio_line;
  logic       sdio_out;
  logic       sdio_oe_n;
  logic       ref_in;
  logic       clk_valid;
  logic       align_done;
  logic       cal_done;
  logic       init_done;
  logic       clk_input_enable;
  logic       bias_cal_pulse;
  logic       delay_cal_pulse;
  logic       divider_init_pulse;
  logic       align_run;
  logic [7:0] clock_output_en;
  logic [7:0] sysref_output_en;
  logic       sysref_crosspoint;
  logic [2:0] seen_ff = 3'b000;
  int         fail_count = 0;
  int         n_compared = 0;

  // Short start-up count keeps the run brief.
  tws_port #(.CLK_OFF_CNT(200), .FIFO_DEPTH(8)) i_dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .sclk_pin(sclk_pin),
    .chip_select_n(chip_select_n), .sdio_in(sdio_line), .sdio_out(sdio_out),
    .sdio_oe_n(sdio_oe_n), .ref_in(ref_in), .clk_valid(clk_valid),
    .align_done(align_done), .cal_done(cal_done), .init_done(init_done),
    .clk_input_enable(clk_input_enable), .bias_cal_pulse(bias_cal_pulse),
    .delay_cal_pulse(delay_cal_pulse), .divider_init_pulse(divider_init_pulse),
    .align_run(align_run), .clock_output_en(clock_output_en),
    .sysref_output_en(sysref_output_en), .sysref_crosspoint(sysref_crosspoint));

  tws_master_model i_master (
    .clk(clk), .sclk_pin(sclk_pin), .chip_select_n(chip_select_n),
    .sdio_line(sdio_line), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n));

  // ************************************************************
  // Clock, pulse catcher and tasks
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // One-cycle start pulses are caught here so no edge is missed.
  always @(posedge clk) seen_ff <= seen_ff | {divider_init_pulse, delay_cal_pulse, bias_cal_pulse};

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
    // A write into the reserved top range is a bench fault and counts as one.
    if (a >= ADDR_FORBID_LO) fail_count++;
    i_master.open_frame();
    i_master.send({a, 1'b0}, 8);
    i_master.send(d, 8);
    i_master.close_frame();
  endtask

  task automatic reg_read(input logic [6:0] a, input logic e1, output logic [7:0] d);
    i_master.open_frame();
    i_master.send({a, 1'b1}, 8);
    i_master.recv(e1, d);
    i_master.close_frame();
  endtask

  task automatic expect_reg(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    reg_read(a, 1'b0, d);
    check(d, exp);
  endtask

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // A hang is cut off well past the expected length of the sequence.
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    complete_run();
  end

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    logic [7:0] d;
    ce         = 1'b1;
    clk_valid  = 1'b1;
    ref_in     = 1'b0;
    align_done = 1'b0;
    cal_done   = 1'b0;
    init_done  = 1'b0;
    rst_n      = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check({7'h00, clk_input_enable}, 8'h00);
    check(clock_output_en, RST_CLK_OE);
    check(sysref_output_en, RST_SYS_OE);
    reg_read(ADDR_STATUS, 1'b0, d);
    check({7'h00, d[BIT_READY]}, 8'h00);
    repeat (200) @(posedge clk);
    check({7'h00, clk_input_enable}, 8'h01);
    reg_read(ADDR_STATUS, 1'b0, d);
    check({7'h00, d[BIT_READY]}, 8'h01);
    expect_reg(ADDR_CLK_OE, RST_CLK_OE);
    expect_reg(ADDR_SYS_OE, RST_SYS_OE);
    $display("test start-up done");
    reg_write(ADDR_CLK_OE, 8'h5A);
    check(clock_output_en, 8'h5A);
    expect_reg(ADDR_CLK_OE, 8'h5A);
    i_master.open_frame();
    i_master.send({ADDR_CLK_OE, 1'b0}, 8);
    i_master.send(8'hA5, 8);
    i_master.send(8'h11, 8);
    i_master.send(8'h3C, 8);
    i_master.close_frame();
    check(clock_output_en, 8'hA5);
    check(sysref_output_en, 8'h3C);
    i_master.open_frame();
    i_master.send({ADDR_CLK_OE, 1'b1}, 8);
    i_master.recv(1'b0, d);
    check(d, 8'hA5);
    i_master.recv(1'b0, d);
    i_master.recv(1'b0, d);
    check(d, 8'h3C);
    i_master.close_frame();
    reg_write(ADDR_SPI_CTRL, 8'h01);
    reg_read(ADDR_CLK_OE, 1'b1, d);
    check(d, 8'hA5);
    reg_write(ADDR_SPI_CTRL, 8'h00);
    i_master.open_frame();
    i_master.send({ADDR_CLK_OE, 1'b0}, 8);
    i_master.send(8'h00, 3);
    i_master.close_frame();
    check(clock_output_en, 8'hA5);
    expect_reg(ADDR_CLK_OE, 8'hA5);
    $display("test transfers done");
    reg_write(ADDR_CAL_CTRL, 8'h03);
    check({6'h00, seen_ff[1:0]}, 8'h03);
    cal_done <= 1'b1;
    repeat (4) @(posedge clk);
    expect_reg(ADDR_CAL_CTRL, 8'h00);
    cal_done <= 1'b0;
    reg_write(ADDR_ALIGN_CTRL, 8'h01);
    reg_read(ADDR_STATUS, 1'b0, d);
    check({7'h00, d[BIT_ALIGN_ACT]}, 8'h01);
    check({7'h00, align_run}, 8'h00);
    clk_valid <= 1'b0;
    ref_in    <= 1'b1;
    repeat (8) @(posedge clk);
    check({7'h00, align_run}, 8'h00);
    clk_valid <= 1'b1;
    ref_in    <= 1'b0;
    repeat (4) @(posedge clk);
    ref_in <= 1'b1;
    repeat (8) @(posedge clk);
    check({7'h00, align_run}, 8'h01);
    align_done <= 1'b1;
    ref_in     <= 1'b0;
    repeat (4) @(posedge clk);
    reg_read(ADDR_STATUS, 1'b0, d);
    check({7'h00, d[BIT_ALIGN_ACT]}, 8'h00);
    expect_reg(ADDR_ALIGN_CTRL, 8'h00);
    align_done <= 1'b0;
    $display("test triggers done");
    reg_write(ADDR_INIT_CTRL, 8'h01);
    check(clock_output_en, 8'h00);
    check(sysref_output_en, 8'h00);
    check({7'h00, seen_ff[2]}, 8'h01);
    init_done <= 1'b1;
    repeat (24) @(posedge clk);
    expect_reg(ADDR_INIT_CTRL, 8'h00);
    check(clock_output_en, 8'hA5);
    init_done <= 1'b0;
    reg_write(ADDR_SYSREF_CTL, 8'h01);
    reg_write(ADDR_SYSREF_CTL, 8'h03);
    reg_write(ADDR_SYSREF_CTL, 8'h01);
    check({7'h00, sysref_crosspoint}, 8'h01);
    check(clock_output_en, 8'hA5);
    check(sysref_output_en, 8'h3C);
    $display("test init and coupling done");
    complete_run();
  end
endmodule
`default_nettype wire
